// File: pkg/dma_defines.svh
// constants for the two-channel transfer sequencer: address windows, field widths, resets
// assumes a 16-bit data address space with internal RAM below the register bank
//
// Behaviour
// - while one channel is transferring, a request on the other channel waits.
// - a waiting request is served as soon as the running transfer has finished.
// - when both channels ask in the same cycle, channel 0 goes first.
// - a transfer and a CPU interrupt arriving together are ordered transfer first, interrupt next.
// - no transfer is granted in the cycle right after a call, table call, break or flag bit op.
// - the RAM-side address steps up by one after each transfer with no wrap or clamp at RAM edges.
// - register-to-RAM transfers to an address in the register bank or outside RAM store nothing.
// - RAM-to-register transfers from an out-of-range address deliver undefined data to the target.
// - the transfer-active flag clears itself when the programmed count runs out.
// - the operation enable bit may only be written while the transfer-active flag is low.
`ifndef DMA_DEFINES_SVH
`define DMA_DEFINES_SVH

`define DMA_ADDR_W      16
`define DMA_CNT_W       10
`define DMA_SFR_W       8
`define DMA_RAM_LO      16'hF_B00
`define DMA_GPR_LO      16'hF_EE0
`define DMA_ADDR_RST    16'h0000
`define DMA_CNT_RST     10'h000
`define DMA_SFR_RST     8'h00
`define DMA_DATA_RST    8'h00

`endif

// File: pkg/dma_pkg.sv
// types shared by the sequencer and its channel slices
package dma_pkg;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_READ  = 2'b01,
        ST_WRITE = 2'b10
    } seq_state_e;

    // software-side programming of one channel
    typedef struct packed {
        logic        load;       // one-cycle strobe: take ram_addr, sfr_addr, count, to_sfr
        logic [15:0] ram_addr;
        logic [7:0]  sfr_addr;
        logic [15:0] count;
        logic        to_sfr;     // 1: RAM to register, 0: register to RAM
        logic        act_wr;     // strobe: write act_val into the transfer-active flag
        logic        act_val;
        logic        en_wr;      // strobe: write en_val into the operation enable
        logic        en_val;
        logic        hold;       // transfer hold control, level
    } chan_cfg_s;

    // one access on the internal bus
    typedef struct packed {
        logic        strobe;
        logic        is_ram;
        logic [15:0] addr;
        logic [7:0]  data;
    } bus_acc_s;

endpackage : dma_pkg

// File: core/dma_channel.sv
// one channel slice: enable, active flag, address, count and its pending request
// assumes trigger, cfg and done come from logic on core_clk
`timescale 1ns/10ps
`default_nettype none
`include "dma_defines.svh"

module dma_channel (
    input  wire logic                       core_clk,
    input  wire logic                       arst_n,
    input  wire dma_pkg::chan_cfg_s         cfg,
    input  wire logic                       trig,
    input  wire logic                       grant,
    input  wire logic                       done,
    output logic                            pending_r,
    output logic                            enable_r,
    output logic                            active_r,
    output logic                            to_sfr_r,
    output logic [`DMA_ADDR_W-1:0]          ram_addr_r,
    output logic [`DMA_SFR_W-1:0]           sfr_addr_r,
    output logic [`DMA_CNT_W-1:0]           count_r,
    output logic                            done_irq_r
);
    wire last_xfer   = done && (count_r == `DMA_CNT_W'(1));
    wire trig_ok     = trig && enable_r && active_r;
    // bits above the count width are ignored; software keeps them zero
    wire [`DMA_CNT_W-1:0] count_ld = cfg.count[`DMA_CNT_W-1:0];
    wire en_wr_ok    = cfg.en_wr && !active_r;
    wire pending_nxt = trig_ok || (pending_r && !grant);                   // set wins
    wire active_nxt  = last_xfer ? 1'b0 : (cfg.act_wr ? cfg.act_val : active_r);

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pending_r  <= 1'b0;
            enable_r   <= 1'b0;
            active_r   <= 1'b0;
            to_sfr_r   <= 1'b0;
            ram_addr_r <= `DMA_ADDR_RST;
            sfr_addr_r <= `DMA_SFR_RST;
            count_r    <= `DMA_CNT_RST;
            done_irq_r <= 1'b0;
        end else begin
            pending_r  <= pending_nxt && active_nxt;
            active_r   <= active_nxt;
            done_irq_r <= last_xfer;
            if (en_wr_ok) begin
                enable_r <= cfg.en_val;
            end
            if (cfg.load && !active_r) begin
                ram_addr_r <= cfg.ram_addr;
                sfr_addr_r <= cfg.sfr_addr;
                count_r    <= count_ld;
                to_sfr_r   <= cfg.to_sfr;
            end else if (done) begin
                ram_addr_r <= ram_addr_r + `DMA_ADDR_W'(1);
                count_r    <= count_r - `DMA_CNT_W'(1);
            end
        end
    end

    a_done_irq_last: assert property (@(posedge core_clk) disable iff (!arst_n)
        last_xfer |=> done_irq_r && !active_r)
        else $error("done interrupt or active clear missing after last transfer");

    a_addr_step: assert property (@(posedge core_clk) disable iff (!arst_n)
        (done && !cfg.load) |=> ram_addr_r == $past(ram_addr_r) + `DMA_ADDR_W'(1))
        else $error("ram address did not step by one");

    a_enable_locked: assert property (@(posedge core_clk) disable iff (!arst_n)
        (active_r && $past(active_r)) |-> $stable(enable_r))
        else $error("enable changed while transfer active");

endmodule : dma_channel
`default_nettype wire

// File: core/dma_arbiter.sv
// two-channel transfer sequencer: arbitration, cpu interlock and the bus access sequence
// assumes triggers, cpu status and bus read data are on core_clk; read data follows strobe by one
`timescale 1ns/10ps
`default_nettype none
`include "dma_defines.svh"

module dma_arbiter (
    input  wire logic                   core_clk,
    input  wire logic                   arst_n,
    input  wire dma_pkg::chan_cfg_s     cfg0,
    input  wire dma_pkg::chan_cfg_s     cfg1,
    input  wire logic [1:0]             trig,
    input  wire logic                   cpu_hold_insn,
    input  wire logic                   cpu_irq_req,
    input  wire logic [`DMA_SFR_W-1:0]  rd_data,
    output dma_pkg::bus_acc_s           rd_acc_r,
    output dma_pkg::bus_acc_s           wr_acc_r,
    output logic                        range_err_r,
    output logic                        irq_allow_r,
    output logic                        busy_r,
    output logic [1:0]                  enable_r,
    output logic [1:0]                  active_r,
    output logic [1:0]                  done_irq_r
);
    dma_pkg::seq_state_e state_r;
    dma_pkg::seq_state_e state_nxt;
    logic                cur_ch_r;
    logic                hold_insn_r;
    logic [1:0]          pending;
    logic [1:0]          done;
    logic [1:0]          grant;
    logic [1:0]          to_sfr;
    logic [`DMA_ADDR_W-1:0] ram_addr [2];
    logic [`DMA_SFR_W-1:0]  sfr_addr [2];

    dma_channel u_ch0 (
        .core_clk   (core_clk),
        .arst_n     (arst_n),
        .cfg        (cfg0),
        .trig       (trig[0]),
        .grant      (grant[0]),
        .done       (done[0]),
        .pending_r  (pending[0]),
        .enable_r   (enable_r[0]),
        .active_r   (active_r[0]),
        .to_sfr_r   (to_sfr[0]),
        .ram_addr_r (ram_addr[0]),
        .sfr_addr_r (sfr_addr[0]),
        .count_r    (),
        .done_irq_r (done_irq_r[0])
    );

    dma_channel u_ch1 (
        .core_clk   (core_clk),
        .arst_n     (arst_n),
        .cfg        (cfg1),
        .trig       (trig[1]),
        .grant      (grant[1]),
        .done       (done[1]),
        .pending_r  (pending[1]),
        .enable_r   (enable_r[1]),
        .active_r   (active_r[1]),
        .to_sfr_r   (to_sfr[1]),
        .ram_addr_r (ram_addr[1]),
        .sfr_addr_r (sfr_addr[1]),
        .count_r    (),
        .done_irq_r (done_irq_r[1])
    );

    // a channel with its hold set is skipped; holding only one of two busy
    // channels is not a reliable pause, software holds both
    wire ready0    = pending[0] && !cfg0.hold;
    wire ready1    = pending[1] && !cfg1.hold;
    wire idle      = (state_r == dma_pkg::ST_IDLE);
    wire may_grant = idle && !hold_insn_r;
    wire pick1     = !ready0;
    wire start     = may_grant && (ready0 || ready1);
    assign grant   = start ? (pick1 ? 2'b10 : 2'b01) : 2'b00;

    wire                   sel_to_sfr = to_sfr[cur_ch_r];
    wire [`DMA_ADDR_W-1:0] sel_ram    = ram_addr[cur_ch_r];
    wire [`DMA_SFR_W-1:0]  sel_sfr    = sfr_addr[cur_ch_r];
    wire                   g_to_sfr   = to_sfr[pick1];
    wire [`DMA_ADDR_W-1:0] g_ram      = ram_addr[pick1];
    wire [`DMA_SFR_W-1:0]  g_sfr      = sfr_addr[pick1];
    // ram below the window, in the register bank or past it is out of range
    wire ram_bad = (sel_ram < `DMA_RAM_LO) || (sel_ram >= `DMA_GPR_LO);
    wire at_write = (state_r == dma_pkg::ST_WRITE);
    assign done  = at_write ? (cur_ch_r ? 2'b10 : 2'b01) : 2'b00;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            dma_pkg::ST_IDLE:  if (start) state_nxt = dma_pkg::ST_READ;
            dma_pkg::ST_READ:  state_nxt = dma_pkg::ST_WRITE;
            dma_pkg::ST_WRITE: state_nxt = dma_pkg::ST_IDLE;
            default:           state_nxt = dma_pkg::ST_IDLE;
        endcase
    end

    // write strobe stays low for a register-to-RAM access out of range:
    // the byte is dropped rather than clobbering registers
    wire wr_strobe_nxt = at_write && (sel_to_sfr || !ram_bad);
    // RAM-to-register from a bad address still writes whatever the bus returned
    wire range_err_nxt = at_write && ram_bad;
    // interrupt service waits while a transfer runs or a channel without hold has one pending; a trigger
    // landing this very cycle counts too, since its pending bit is not yet visible
    wire [1:0] trig_live     = trig & enable_r & active_r;
    wire       irq_allow_nxt = cpu_irq_req && idle && !start && !ready0 && !ready1
                               && (trig_live == 2'b00);

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r     <= dma_pkg::ST_IDLE;
            cur_ch_r    <= 1'b0;
            hold_insn_r <= 1'b0;
            busy_r      <= 1'b0;
            irq_allow_r <= 1'b0;
            range_err_r <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            hold_insn_r <= cpu_hold_insn;
            busy_r      <= (state_nxt != dma_pkg::ST_IDLE);
            irq_allow_r <= irq_allow_nxt;
            range_err_r <= range_err_nxt;
            if (start) begin
                cur_ch_r <= pick1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_acc_r <= '0;
            wr_acc_r <= '0;
        end else begin
            rd_acc_r.strobe <= start;
            rd_acc_r.is_ram <= start ? g_to_sfr : rd_acc_r.is_ram;
            rd_acc_r.addr   <= start ? (g_to_sfr ? g_ram : {8'h00, g_sfr}) : rd_acc_r.addr;
            rd_acc_r.data   <= `DMA_DATA_RST;
            wr_acc_r.strobe <= wr_strobe_nxt;
            if (at_write) begin
                wr_acc_r.is_ram <= !sel_to_sfr;
                wr_acc_r.addr   <= sel_to_sfr ? {8'h00, sel_sfr} : sel_ram;
                wr_acc_r.data   <= rd_data;
            end
        end
    end

    // a transfer runs idle -> read -> write -> idle
    sequence s_xfer;
        state_r == dma_pkg::ST_READ ##1 state_r == dma_pkg::ST_WRITE ##1 idle;
    endsequence

    // read strobe out with the engine busy, then the write (or its drop flag) two cycles on
    sequence s_rd_wr;
        rd_acc_r.strobe && busy_r ##2 (wr_acc_r.strobe || range_err_r);
    endsequence

    // busy covers the read and write cycles and falls as the engine returns to idle
    sequence s_busy;
        busy_r [*2] ##1 !busy_r;
    endsequence

    // an interrupt that meets a quiet engine: nothing running, waiting or arriving
    sequence s_quiet_irq;
        cpu_irq_req && idle && !ready0 && !ready1 && (trig_live == 2'b00);
    endsequence

    a_xfer_walk: assert property (@(posedge core_clk) disable iff (!arst_n)
        start |=> s_xfer)
        else $error("transfer sequence broken");

    a_no_preempt: assert property (@(posedge core_clk) disable iff (!arst_n)
        !idle |-> grant == 2'b00)
        else $error("grant issued during running transfer");

    a_ch0_first: assert property (@(posedge core_clk) disable iff (!arst_n)
        (start && ready0 && ready1) |-> grant == 2'b01 ##1 !cur_ch_r)
        else $error("channel 1 won a tie");

    a_insn_holdoff: assert property (@(posedge core_clk) disable iff (!arst_n)
        cpu_hold_insn |=> !start)
        else $error("transfer granted right after hold instruction");

    a_irq_after: assert property (@(posedge core_clk) disable iff (!arst_n)
        (start && cpu_irq_req) |=> !irq_allow_r [*3])
        else $error("interrupt allowed ahead of transfer");

    a_drop_bad: assert property (@(posedge core_clk) disable iff (!arst_n)
        (at_write && !sel_to_sfr && ram_bad) |=> !wr_acc_r.strobe && range_err_r)
        else $error("out of range byte stored to RAM");

    a_wait_served: assert property (@(posedge core_clk) disable iff (!arst_n)
        (at_write && (cur_ch_r ? ready0 : ready1) && !hold_insn_r && !cpu_hold_insn)
        |=> start)
        else $error("waiting request not served after transfer");

    a_access_pair: assert property (@(posedge core_clk) disable iff (!arst_n)
        start |=> s_rd_wr)
        else $error("read and write accesses out of step");

    a_busy_span: assert property (@(posedge core_clk) disable iff (!arst_n)
        start |=> s_busy)
        else $error("busy does not cover the transfer");

    a_irq_vs_trig: assert property (@(posedge core_clk) disable iff (!arst_n)
        (cpu_irq_req && (trig_live != 2'b00)) |=> !irq_allow_r)
        else $error("interrupt allowed alongside a new transfer request");

    a_irq_released: assert property (@(posedge core_clk) disable iff (!arst_n)
        s_quiet_irq |=> irq_allow_r)
        else $error("interrupt withheld from a quiet engine");

    a_reg_write: assert property (@(posedge core_clk) disable iff (!arst_n)
        (at_write && sel_to_sfr)
        |=> wr_acc_r.strobe && !wr_acc_r.is_ram && wr_acc_r.data == $past(rd_data))
        else $error("register write lost or carrying wrong data");

    a_range_flag: assert property (@(posedge core_clk) disable iff (!arst_n)
        (at_write && sel_to_sfr && ram_bad) |=> wr_acc_r.strobe && range_err_r)
        else $error("out of range read not flagged");

    a_hold_skip: assert property (@(posedge core_clk) disable iff (!arst_n)
        (cfg0.hold && cfg1.hold) |-> grant == 2'b00)
        else $error("grant issued while both channels held");

endmodule : dma_arbiter
`default_nettype wire

// File: bench/bus_responder.sv
// behavioural RAM and register bank answering the sequencer's reads
// assumes reads are one-cycle strobes on core_clk and data is due the next cycle
`timescale 1ns/10ps
`default_nettype none
module bus_responder (
    input  wire logic              core_clk,
    input  wire logic              arst_n,
    input  wire dma_pkg::bus_acc_s rd_acc,
    output logic [7:0]             rd_data
);
    // content is a hash of the address; between reads the bus flips so stale data never passes
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data <= 8'h00;
        end else if (rd_acc.strobe) begin
            rd_data <= rd_acc.addr[7:0] ^ rd_acc.addr[15:8] ^ {7'h00, rd_acc.is_ram};
        end else begin
            rd_data <= ~rd_data;
        end
    end
endmodule : bus_responder
`default_nettype wire

// File: bench/dual_channel_dma_arbiter_tb.sv
// self-checking bench for the two-channel transfer sequencer
// assumes bus_responder stands in for RAM and registers on the bus side
`timescale 1ns/10ps
`default_nettype none
`include "dma_defines.svh"
module dual_channel_dma_arbiter_tb;
    logic               core_clk = 1'b0;
    logic               arst_n;
    dma_pkg::chan_cfg_s cfg [2];
    logic [1:0]         trig;
    logic               cpu_hold_insn;
    logic               cpu_irq_req;
    logic [7:0]         rd_data;
    dma_pkg::bus_acc_s  rd_acc_r;
    dma_pkg::bus_acc_s  wr_acc_r;
    logic               range_err_r;
    logic               irq_allow_r;
    logic               busy_r;
    logic [1:0]         enable_r;
    logic [1:0]         active_r;
    logic [1:0]         done_irq_r;
    int                 num_errors = 0;
    int                 checks_done = 0;
    int                 seed;
    logic [15:0]        ram_a [2];
    logic [7:0]         sfr_a [2];
    logic               dir [2];
    int                 cnt [2];

    always #10 core_clk = ~core_clk;

    dma_arbiter u_dut (.core_clk(core_clk), .arst_n(arst_n), .cfg0(cfg[0]), .cfg1(cfg[1]),
        .trig(trig), .cpu_hold_insn(cpu_hold_insn), .cpu_irq_req(cpu_irq_req),
        .rd_data(rd_data), .rd_acc_r(rd_acc_r), .wr_acc_r(wr_acc_r),
        .range_err_r(range_err_r), .irq_allow_r(irq_allow_r), .busy_r(busy_r),
        .enable_r(enable_r), .active_r(active_r), .done_irq_r(done_irq_r));
    bus_responder u_bus (.core_clk(core_clk), .arst_n(arst_n), .rd_acc(rd_acc_r),
        .rd_data(rd_data));

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim

    function automatic logic [15:0] rnd_ram();
        return 16'hfb00 + 16'($random(seed) & 32'h0000_01ff);
    endfunction : rnd_ram

    task automatic prog(input int ch, input logic [15:0] ra, input int n, input logic d);
        ram_a[ch] = ra;
        sfr_a[ch] = 8'($random(seed));
        dir[ch] = d;
        cnt[ch] = n;
        @(posedge core_clk);
        cfg[ch].load <= 1'b1;
        cfg[ch].ram_addr <= ra;
        cfg[ch].sfr_addr <= sfr_a[ch];
        cfg[ch].count <= {6'h00, 10'(n)};
        cfg[ch].to_sfr <= d;
        cfg[ch].en_val <= 1'b1;
        cfg[ch].act_val <= 1'b1;
        @(posedge core_clk);
        cfg[ch].load <= 1'b0;
        cfg[ch].en_wr <= 1'b1;
        @(posedge core_clk);
        cfg[ch].en_wr <= 1'b0;
        cfg[ch].act_wr <= 1'b1;
        @(posedge core_clk);
        cfg[ch].act_wr <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        chk("enable_active", 16'h0003, {14'h0000, enable_r[ch], active_r[ch]});
    endtask : prog

    // one byte on channel ch; lat is edges from the trigger edge to the read strobe
    task automatic xfer(input int ch, input bit fire, input bit hold, input bit irq, input int lat);
        logic [15:0] ra;
        logic        err;
        int          n;
        logic        seen;
        ra = dir[ch] ? ram_a[ch] : {8'h00, sfr_a[ch]};
        err = !(ram_a[ch] >= `DMA_RAM_LO && ram_a[ch] < `DMA_GPR_LO);
        n = 0;
        seen = 1'b0;
        if (fire) begin
            @(posedge core_clk);
            trig[ch] <= 1'b1;
            cpu_hold_insn <= hold;
            cpu_irq_req <= irq;
        end
        do begin
            @(posedge core_clk);
            trig <= 2'b00;
            cpu_hold_insn <= 1'b0;
            #1;
            n++;
            seen |= irq_allow_r;
        end while (rd_acc_r.strobe !== 1'b1 && n < 20);
        chk("grant_latency", 16'(lat), 16'(n));
        chk("rd_addr", ra, rd_acc_r.addr);
        chk("rd_is_ram", 16'(dir[ch]), 16'(rd_acc_r.is_ram));
        chk("busy", 16'h0001, 16'(busy_r));
        repeat (2) begin
            @(posedge core_clk);
            #1;
            seen |= irq_allow_r;
        end
        chk("irq_held", 16'h0000, 16'(seen));
        chk("wr_strobe", 16'(!(err && !dir[ch])), 16'(wr_acc_r.strobe));
        chk("range_err", 16'(err), 16'(range_err_r));
        chk("busy_end", 16'h0000, 16'(busy_r));
        if (wr_acc_r.strobe === 1'b1) begin
            chk("wr_addr", dir[ch] ? {8'h00, sfr_a[ch]} : ram_a[ch], wr_acc_r.addr);
            chk("wr_data", 16'(ra[7:0] ^ ra[15:8] ^ {7'h00, dir[ch]}), 16'(wr_acc_r.data));
        end
        chk("done_irq", 16'(cnt[ch] == 1), 16'(done_irq_r[ch]));
        chk("active", 16'(cnt[ch] != 1), 16'(active_r[ch]));
        ram_a[ch]++;
        cnt[ch]--;
        if (irq) begin
            n = 0;
            while (irq_allow_r !== 1'b1 && n < 4) begin
                @(posedge core_clk);
                #1;
                n++;
            end
            chk("irq_after", 16'h0001, 16'(irq_allow_r));
            @(posedge core_clk);
            cpu_irq_req <= 1'b0;
        end
    endtask : xfer

    initial begin
        int ch;
        int n;
        bit h;
        seed = 32'hc8f0;
        arst_n = 1'b0;
        cfg[0] = '0;
        cfg[1] = '0;
        trig = 2'b00;
        cpu_hold_insn = 1'b0;
        cpu_irq_req = 1'b0;
        repeat (16) @(posedge core_clk);
        arst_n <= 1'b1;
        prog(1, rnd_ram(), 2, 1'b1);
        xfer(1, 1, 1, 0, 3);
        xfer(1, 1, 0, 1, 2);
        $display("test hold and irq done");
        prog(0, rnd_ram(), 1, 1'b0);
        prog(1, rnd_ram(), 1, 1'b1);
        @(posedge core_clk);
        trig <= 2'b11;
        xfer(0, 0, 0, 0, 2);
        xfer(1, 0, 0, 0, 1);
        $display("test tie done");
        prog(0, rnd_ram(), 1, 1'b0);
        prog(1, rnd_ram(), 1, 1'b1);
        @(posedge core_clk);
        cfg[0].hold <= 1'b1;
        cfg[1].hold <= 1'b1;
        trig <= 2'b11;
        @(posedge core_clk);
        trig <= 2'b00;
        repeat (4) @(posedge core_clk);
        #1;
        chk("held_busy", 16'h0000, {15'h0000, busy_r});
        @(posedge core_clk);
        cfg[0].hold <= 1'b0;
        cfg[1].hold <= 1'b0;
        xfer(0, 0, 0, 0, 1);
        xfer(1, 0, 0, 0, 1);
        $display("test hold done");
        prog(0, 16'hfedf, 2, 1'b0);
        repeat (2) xfer(0, 1, 0, 0, 2);
        prog(1, 16'hfaff, 2, 1'b1);
        repeat (2) xfer(1, 1, 0, 0, 2);
        $display("test range done");
        for (int i = 0; i < 6; i++) begin
            ch = $random(seed) & 1;
            n = 1 + (($random(seed) & 32'h0000_00ff) % 3);
            prog(ch, rnd_ram(), n, 1'($random(seed)));
            repeat (n) begin
                h = 1'($random(seed));
                xfer(ch, 1, h, 0, h ? 3 : 2);
            end
        end
        $display("test random done");
        prog(0, rnd_ram(), 2, 1'b0);
        @(posedge core_clk);
        cfg[0].en_val <= 1'b0;
        cfg[0].act_val <= 1'b0;
        cfg[0].en_wr <= 1'b1;
        @(posedge core_clk);
        cfg[0].en_wr <= 1'b0;
        cfg[0].act_wr <= 1'b1;
        #1;
        chk("enable_locked", 16'h0001, 16'(enable_r[0]));
        @(posedge core_clk);
        cfg[0].act_wr <= 1'b0;
        cfg[0].en_wr <= 1'b1;
        @(posedge core_clk);
        cfg[0].en_wr <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        chk("enable_cleared", 16'h0000, {14'h0000, enable_r[0], active_r[0]});
        $display("test enable lock done");
        end_sim();
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        $display("watchdog expired");
        end_sim();
    end
endmodule : dual_channel_dma_arbiter_tb
`default_nettype wire
